// >>> logic/fppc_sequencer.sv
// Phrase program and write-once command sequencer with register port
//
// Functional notes
// - Code 0x06 plus address bits 23-16
// - Misaligned phrase address sets access error
// - Launch programs, reads back, sets complete
// - Index other than 101 sets access error
// - Command not allowed in mode: access error
// - Address outside program flash: access error
// - Protected address sets violation, no program
// - Any verify error sets upper status
// - Non-correctable verify error sets lower status
// - Code 0x07, phrase index 0-7, words
// - Write-once: blank check, program, verify
// - Phrase index out of range: access error
// - Already programmed write-once phrase refused
// - Array reads invalid during write-once
// - Write-once field is 64 bytes, 8 phrases
// - All-ones phrase may be written again
//
// Implementation choices: the strobed register port and the placing of the registers.
`timescale 1ns/100ps
module fppc_sequencer
  import fppc_pkg::*;
(
  input wire logic i_clk_sys,
  input wire logic i_rst,
  input wire logic [7:0] i_addr,
  input wire logic [15:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [15:0] o_rdata,
  output logic o_nvm_req,
  output logic o_nvm_write,
  output logic o_nvm_info,
  output logic [23:0] o_nvm_addr,
  output logic [63:0] o_nvm_wdata,
  input wire logic i_nvm_ack,
  input wire logic [63:0] i_nvm_rdata,
  input wire logic i_nvm_err_corr,
  input wire logic i_nvm_err_uncorr,
  output logic o_pflash_read_block,
  output logic o_busy
);

  fppc_state_type state_r; // Sequencer state
  fppc_state_type state_nxt; // Next sequencer state
  logic [15:0] slot_r [0:5]; // Command parameter buffer
  logic [2:0] index_r; // Command buffer index
  logic [1:0] mode_r; // Mode permissions
  logic [8:0] prot_r; // Protection boundary and enable
  logic done_flag_r; // Command complete flag
  logic acc_err_r; // Access error flag
  logic prot_viol_r; // Protection violation flag
  logic mgs1_r; // Upper verify status
  logic mgs0_r; // Lower verify status
  logic [15:0] rdata_r; // Read data register
  logic [23:0] nvm_addr_r; // Latched target address
  logic [63:0] nvm_wdata_r; // Latched phrase data
  logic nvm_info_r; // Target is the information area
  logic once_r; // Running command is write-once
  logic chk_acc_err; // Launch check access error
  logic chk_prot_viol; // Launch check protection violation
  logic wr_status; // Write to the status register
  logic launch; // Software cleared the complete flag
  logic set_acc_err; // Hardware sets access error
  logic set_prot_viol; // Hardware sets protection violation
  logic set_mgs1; // Hardware sets upper verify status
  logic set_mgs0; // Hardware sets lower verify status
  logic phrase_bad; // Read-back differs from latched data
  logic [23:0] cmd_addr; // Address assembled from the slots

  assign wr_status = i_wr && (i_addr == OFF_STATUS);
  // Writing one to the complete bit clears it and launches
  assign launch = wr_status && i_wdata[FLD_DONE] && done_flag_r;
  assign cmd_addr = {slot_r[0][7:0], slot_r[1]};
  assign phrase_bad = (i_nvm_rdata != nvm_wdata_r);

  // Checks run on the buffer as it stands in the check cycle
  fppc_launch_check u_check (
    .i_cmd(slot_r[0][15:8]),
    .i_index(index_r),
    .i_mode(mode_r),
    .i_addr(cmd_addr),
    .i_once_idx(slot_r[1]),
    .i_prot(prot_r),
    .o_acc_err(chk_acc_err),
    .o_prot_viol(chk_prot_viol)
  );

  // Next state
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE: begin
        if (launch) begin
          state_nxt = ST_CHECK;
        end
      end
      ST_CHECK: begin
        if (chk_acc_err || chk_prot_viol) begin
          state_nxt = ST_DONE;
        end else if (slot_r[0][15:8] == CMD_ONCE) begin
          state_nxt = ST_BLANK;
        end else begin
          state_nxt = ST_PROG;
        end
      end
      ST_BLANK: begin
        if (i_nvm_ack) begin
          // Only an all-ones phrase counts as blank
          if (i_nvm_rdata == ERASED) begin
            state_nxt = ST_PROG;
          end else begin
            state_nxt = ST_DONE;
          end
        end
      end
      ST_PROG: begin
        if (i_nvm_ack) begin
          state_nxt = ST_VERIFY;
        end
      end
      ST_VERIFY: begin
        if (i_nvm_ack) begin
          state_nxt = ST_DONE;
        end
      end
      ST_DONE: begin
        state_nxt = ST_IDLE;
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
  end

  // State register
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      state_r <= ST_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Hardware set terms for the status flags
  always_comb begin
    set_acc_err = 1'b0;
    set_prot_viol = 1'b0;
    set_mgs1 = 1'b0;
    set_mgs0 = 1'b0;
    if (state_r == ST_CHECK) begin
      set_acc_err = chk_acc_err;
      set_prot_viol = chk_prot_viol && !chk_acc_err;
    end
    if (state_r == ST_BLANK && i_nvm_ack && i_nvm_rdata != ERASED) begin
      set_acc_err = 1'b1;
    end
    if (state_r == ST_VERIFY && i_nvm_ack) begin
      // Miscompare is treated as non-correctable
      set_mgs1 = i_nvm_err_corr || i_nvm_err_uncorr || phrase_bad;
      set_mgs0 = i_nvm_err_uncorr || phrase_bad;
    end
  end

  // Command complete flag: low from launch until the sequence ends
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      done_flag_r <= 1'b1;
    end else if (launch) begin
      done_flag_r <= 1'b0;
    end else if (state_r == ST_DONE) begin
      done_flag_r <= 1'b1;
    end
  end

  // Error flags: write one clears, a hardware set wins
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      acc_err_r <= 1'b0;
      prot_viol_r <= 1'b0;
    end else begin
      acc_err_r <= set_acc_err ||
                   (acc_err_r && !(wr_status && i_wdata[FLD_ACC_ERR]));
      prot_viol_r <= set_prot_viol ||
                     (prot_viol_r && !(wr_status && i_wdata[FLD_PROT_VIOL]));
    end
  end

  // Verify status: cleared at launch, set by read-back errors
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      mgs1_r <= 1'b0;
      mgs0_r <= 1'b0;
    end else if (launch) begin
      mgs1_r <= 1'b0;
      mgs0_r <= 1'b0;
    end else begin
      mgs1_r <= mgs1_r || set_mgs1;
      mgs0_r <= mgs0_r || set_mgs0;
    end
  end

  // Buffer index and parameter slots; locked while a command runs
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      index_r <= INDEX_RST;
      for (int i = 0; i < 6; i++) begin
        slot_r[i] <= SLOT_RST;
      end
    end else if (done_flag_r && i_wr) begin
      if (i_addr == OFF_INDEX) begin
        index_r <= i_wdata[2:0];
      end
      // Indices 6 and 7 have no slot, writes there are dropped
      if (i_addr == OFF_DATA && index_r <= IDX_FULL) begin
        slot_r[index_r] <= i_wdata;
      end
    end
  end

  // Mode permissions and protection boundary
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      mode_r <= MODE_RST;
      prot_r <= PROT_RST;
    end else if (done_flag_r && i_wr) begin
      if (i_addr == OFF_MODE) begin
        mode_r <= i_wdata[1:0];
      end
      if (i_addr == OFF_PROT) begin
        prot_r <= i_wdata[8:0];
      end
    end
  end

  // Target latch taken in the check cycle, whether or not the checks pass
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      nvm_addr_r <= 24'h00_0000;
      nvm_wdata_r <= 64'h0000_0000_0000_0000;
      nvm_info_r <= 1'b0;
      once_r <= 1'b0;
    end else if (state_r == ST_CHECK) begin
      once_r <= (slot_r[0][15:8] == CMD_ONCE);
      nvm_info_r <= (slot_r[0][15:8] == CMD_ONCE);
      nvm_wdata_r <= {slot_r[2], slot_r[3], slot_r[4], slot_r[5]};
      if (slot_r[0][15:8] == CMD_ONCE) begin
        // Eight phrases of eight bytes in the information area
        nvm_addr_r <= ONCE_BASE + {18'h0_0000, slot_r[1][2:0], 3'h0};
      end else begin
        nvm_addr_r <= cmd_addr;
      end
    end else if (state_r == ST_DONE) begin
      once_r <= 1'b0;
    end
  end

  // Array request held until the array acknowledges
  assign o_nvm_req = (state_r == ST_BLANK) || (state_r == ST_PROG) ||
                     (state_r == ST_VERIFY);
  assign o_nvm_write = (state_r == ST_PROG);
  assign o_nvm_info = nvm_info_r;
  assign o_nvm_addr = nvm_addr_r;
  assign o_nvm_wdata = nvm_wdata_r;

  // Array reads return invalid data while write-once runs
  assign o_pflash_read_block = once_r;
  assign o_busy = !done_flag_r;

  // Read data, valid only in the cycle after the strobe
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      rdata_r <= 16'h0000;
    end else if (i_rd) begin
      case (i_addr)
        OFF_STATUS: begin
          rdata_r <= 16'h0000;
          rdata_r[FLD_DONE] <= done_flag_r;
          rdata_r[FLD_ACC_ERR] <= acc_err_r;
          rdata_r[FLD_PROT_VIOL] <= prot_viol_r;
          rdata_r[ST_MGS1] <= mgs1_r;
          rdata_r[ST_MGS0] <= mgs0_r;
        end
        OFF_INDEX: begin
          rdata_r <= {13'h0000, index_r};
        end
        OFF_DATA: begin
          rdata_r <= (index_r <= IDX_FULL) ? slot_r[index_r] : 16'h0000;
        end
        OFF_MODE: begin
          rdata_r <= {14'h0000, mode_r};
        end
        OFF_PROT: begin
          rdata_r <= {7'h00, prot_r};
        end
        default: begin
          rdata_r <= 16'h0000; // Unmapped reads as zero
        end
      endcase
    end else begin
      rdata_r <= 16'h0000;
    end
  end

  assign o_rdata = rdata_r;

endmodule : fppc_sequencer

// >>> inc/fppc_pkg.sv
// Constants, register map and state encoding for the phrase program sequencer
package fppc_pkg;

  // Register port geometry
  localparam int FPPC_ADDR_W = 8;
  localparam int FPPC_DATA_W = 16;

  // Register offsets
  localparam logic [7:0] OFF_STATUS = 8'h00; // Flash status register
  localparam logic [7:0] OFF_INDEX = 8'h01; // Command buffer index
  localparam logic [7:0] OFF_DATA = 8'h02; // Parameter slot at the index
  localparam logic [7:0] OFF_MODE = 8'h03; // Operating mode permissions
  localparam logic [7:0] OFF_PROT = 8'h04; // Protection boundary

  // Flash status register field positions
  localparam int FLD_DONE = 7;
  localparam int FLD_ACC_ERR = 5;
  localparam int FLD_PROT_VIOL = 4;
  localparam int ST_MGS1 = 1;
  localparam int ST_MGS0 = 0;

  // Mode register field positions
  localparam int MODE_PROG_OK = 0;
  localparam int MODE_ONCE_OK = 1;

  // Protection register field positions
  localparam int PROT_EN = 8;

  // Reset values
  localparam logic [1:0] MODE_RST = 2'h3;
  localparam logic [8:0] PROT_RST = 9'h000;
  localparam logic [2:0] INDEX_RST = 3'h0;
  localparam logic [15:0] SLOT_RST = 16'h0000;

  // Command codes and launch-time field values
  localparam logic [7:0] CMD_PROG = 8'h06;
  localparam logic [7:0] CMD_ONCE = 8'h07;
  localparam logic [2:0] IDX_FULL = 3'h5;
  localparam logic [2:0] PHRASE_ALIGN = 3'h0;
  localparam logic [15:0] ONCE_IDX_LAST = 16'h0007;

  // Program flash window in the global map
  localparam logic [23:0] PFLASH_LO = 24'hFC_0000;
  localparam logic [23:0] PFLASH_HI = 24'hFF_FFFF;

  // Write-once field base inside the information area
  localparam logic [23:0] ONCE_BASE = 24'h00_0000;

  // Erased phrase content
  localparam logic [63:0] ERASED = 64'hFFFF_FFFF_FFFF_FFFF;

  // Sequencer states, one-hot
  typedef enum logic [5:0] {
    ST_IDLE = 6'b00_0001,
    ST_CHECK = 6'b00_0010,
    ST_BLANK = 6'b00_0100,
    ST_PROG = 6'b00_1000,
    ST_VERIFY = 6'b01_0000,
    ST_DONE = 6'b10_0000
  } fppc_state_type;

endpackage : fppc_pkg

// >>> logic/fppc_launch_check.sv
// Launch-time checks of the buffered command
`timescale 1ns/100ps
module fppc_launch_check
  import fppc_pkg::*;
(
  input wire logic [7:0] i_cmd,
  input wire logic [2:0] i_index,
  input wire logic [1:0] i_mode,
  input wire logic [23:0] i_addr,
  input wire logic [15:0] i_once_idx,
  input wire logic [8:0] i_prot,
  output logic o_acc_err,
  output logic o_prot_viol
);

  // True when the global address lies in program flash
  function automatic logic in_pflash(input logic [23:0] a);
    in_pflash = (a >= PFLASH_LO) && (a <= PFLASH_HI);
  endfunction : in_pflash

  // True when protection is enabled and address bits 17 to 10 sit at or above the boundary
  function automatic logic is_protected(input logic [23:0] a,
                                        input logic [8:0] p);
    is_protected = p[PROT_EN] && (a[17:10] >= p[7:0]);
  endfunction : is_protected

  logic is_prog; // Program-phrase command
  logic is_once; // Write-once command

  assign is_prog = (i_cmd == CMD_PROG);
  assign is_once = (i_cmd == CMD_ONCE);

  // Access errors; unknown codes are refused here too
  always_comb begin
    o_acc_err = 1'b0;
    if (!is_prog && !is_once) begin
      o_acc_err = 1'b1;
    end else if (i_index != IDX_FULL) begin
      o_acc_err = 1'b1;
    end else if (is_prog) begin
      if (!i_mode[MODE_PROG_OK]) begin
        o_acc_err = 1'b1;
      end
      if (!in_pflash(i_addr)) begin
        o_acc_err = 1'b1;
      end
      if (i_addr[2:0] != PHRASE_ALIGN) begin
        o_acc_err = 1'b1;
      end
    end else begin
      if (!i_mode[MODE_ONCE_OK]) begin
        o_acc_err = 1'b1;
      end
      if (i_once_idx > ONCE_IDX_LAST) begin
        o_acc_err = 1'b1;
      end
    end
  end

  // Protection only applies to the program-phrase command
  assign o_prot_viol = is_prog && is_protected(i_addr, i_prot);

endmodule : fppc_launch_check

// >>> testbench/fppc_checker.sv
// Port checker for the phrase program sequencer
`timescale 1ns/100ps
module fppc_checker
  import fppc_pkg::*;
(
  input wire logic i_clk_sys,
  input wire logic i_rst,
  input wire logic [7:0] i_addr,
  input wire logic [15:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [15:0] o_rdata,
  input wire logic o_nvm_req,
  input wire logic o_nvm_write,
  input wire logic o_nvm_info,
  input wire logic [23:0] o_nvm_addr,
  input wire logic i_nvm_ack,
  input wire logic o_pflash_read_block,
  input wire logic o_busy
);
  // One clock domain, so clock and reset are given once
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_rst);
  // Read data only in the cycle after a read strobe
  rd_idle_a: assert property (!$past(i_rd) |-> o_rdata == 16'h0000)
    else $error("read data not idle");
  // Launch clears the complete flag at once
  launch_busy_a: assert property (i_wr && i_addr == OFF_STATUS &&
    i_wdata[FLD_DONE] && !o_busy |=> o_busy) else $error("no launch");
  // Array requests held steady until answered
  req_hold_a: assert property (o_nvm_req && !i_nvm_ack |=> o_nvm_req &&
    $stable(o_nvm_addr) && $stable(o_nvm_write)) else $error("req moved");
  // Array is touched only by a running command
  req_busy_a: assert property (o_nvm_req |-> o_busy)
    else $error("req while idle");
  // Program target aligned and inside program flash
  prog_addr_a: assert property (
    o_nvm_req && o_nvm_write && !o_nvm_info |->
    o_nvm_addr[2:0] == PHRASE_ALIGN && o_nvm_addr >= PFLASH_LO)
    else $error("bad program address");
  // Write-once stays inside the 8-phrase field, reads blocked
  once_field_a: assert property (o_nvm_req && o_nvm_info |->
    o_pflash_read_block && o_nvm_addr - ONCE_BASE < 24'h00_0040)
    else $error("bad once access");
  // Checks take a few cycles only, then request or finish
  launch_quick_a: assert property ($rose(o_busy) |->
    ##[1:4] (o_nvm_req || !o_busy)) else $error("launch stalled");
  // Program ack is followed by the read-back
  prog_verify_a: assert property (
    o_nvm_req && o_nvm_write && i_nvm_ack |->
    ##[1:2] (o_nvm_req && !o_nvm_write)) else $error("no verify");
  // Verify ack ends the program command
  verify_done_a: assert property (
    o_nvm_req && !o_nvm_write && !o_nvm_info && i_nvm_ack |->
    ##[1:4] !o_busy) else $error("no completion");
endmodule : fppc_checker

bind fppc_sequencer fppc_checker u_fppc_checker (
  .i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_addr(i_addr), .i_wdata(i_wdata),
  .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_nvm_req(o_nvm_req),
  .o_nvm_write(o_nvm_write), .o_nvm_info(o_nvm_info),
  .o_nvm_addr(o_nvm_addr), .i_nvm_ack(i_nvm_ack),
  .o_pflash_read_block(o_pflash_read_block), .o_busy(o_busy));

// >>> testbench/tb.sv
// Self-checking bench for the phrase program sequencer
`timescale 1ns/100ps
module tb;
  import fppc_pkg::*;
  logic i_clk_sys = 1'b0;
  logic i_rst = 1'b1;
  logic [7:0] i_addr = 8'h00;
  logic [15:0] i_wdata = 16'h0000;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic i_nvm_ack = 1'b0;
  logic [63:0] i_nvm_rdata = '0;
  logic i_nvm_err_corr = 1'b0;
  logic i_nvm_err_uncorr = 1'b0;
  logic [15:0] o_rdata;
  logic o_nvm_req, o_nvm_write, o_nvm_info, o_pflash_read_block, o_busy;
  logic [23:0] o_nvm_addr, w_addr;
  logic [63:0] o_nvm_wdata, w_data, rv, blank_val;
  logic w_info;
  logic [15:0] slot [6]; // Parameter slots loaded per command
  int err_total = 0;
  int comparisons = 0;
  int cyc = 0;

  fppc_sequencer u_fppc_sequencer (.i_clk_sys(i_clk_sys), .i_rst(i_rst),
    .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
    .o_rdata(o_rdata), .o_nvm_req(o_nvm_req), .o_nvm_write(o_nvm_write),
    .o_nvm_info(o_nvm_info), .o_nvm_addr(o_nvm_addr),
    .o_nvm_wdata(o_nvm_wdata), .i_nvm_ack(i_nvm_ack),
    .i_nvm_rdata(i_nvm_rdata), .i_nvm_err_corr(i_nvm_err_corr),
    .i_nvm_err_uncorr(i_nvm_err_uncorr),
    .o_pflash_read_block(o_pflash_read_block), .o_busy(o_busy));

  // 250 MHz system clock
  initial begin
    forever #2 i_clk_sys = ~i_clk_sys;
  end

  // Verdict and exit, shared with the hang guard
  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : end_sim

  // Hang guard, far above the under one thousand cycles the tests need
  always @(posedge i_clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_total++;
      end_sim();
    end
  end

  task automatic chk(input string n, input logic [63:0] s,
    input logic [63:0] e);
    comparisons++;
    if (s !== e) begin
      err_total++;
      $display("unexpected %s expected %h seen %h", n, e, s);
    end
  endtask : chk

  // One-cycle write strobe
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge i_clk_sys);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_clk_sys);
    i_wr <= 1'b0;
  endtask : wr

  // Read strobe, then data taken in the following cycle only
  task automatic rdc(input logic [7:0] a, input logic [15:0] e,
    input string n);
    @(posedge i_clk_sys);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_clk_sys);
    i_rd <= 1'b0;
    @(posedge i_clk_sys);
    chk(n, o_rdata, e);
  endtask : rdc

  // Answer one array request; errors only on the last one
  task automatic serve(input int k, input int n,
    input logic ec, input logic eu);
    @(posedge i_clk_sys);
    for (int t = 0; t < 60 && o_nvm_req !== 1'b1; t++) @(posedge i_clk_sys);
    chk("array req", o_nvm_req, 1'b1);
    chk("array write", o_nvm_write,
      slot[0][15:8] == CMD_ONCE ? k == 1 : k == 0);
    chk("read block", o_pflash_read_block, slot[0][15:8] == CMD_ONCE);
    if (o_nvm_write === 1'b1) begin
      w_addr = o_nvm_addr;
      w_data = o_nvm_wdata;
      w_info = o_nvm_info;
    end
    i_nvm_ack <= 1'b1;
    i_nvm_rdata <= (k == 0 && o_nvm_info === 1'b1) ? blank_val : rv;
    i_nvm_err_corr <= ec && k == n - 1;
    i_nvm_err_uncorr <= eu && k == n - 1;
    @(posedge i_clk_sys);
    i_nvm_ack <= 1'b0;
  endtask : serve

  // Load slots, launch, serve, check status, clear the sticky flags
  task automatic run(input string n, input logic [2:0] top, input int nreq,
    input logic ec, input logic eu, input logic [15:0] st);
    for (int i = 0; i <= top; i++) begin
      wr(OFF_INDEX, 16'(i));
      wr(OFF_DATA, slot[i]);
    end
    wr(OFF_STATUS, 16'h0080);
    for (int k = 0; k < nreq; k++) serve(k, nreq, ec, eu);
    @(posedge i_clk_sys);
    for (int t = 0; t < 60 && o_busy !== 1'b0; t++) @(posedge i_clk_sys);
    chk("busy", o_busy, 1'b0);
    rdc(OFF_STATUS, st, "status");
    wr(OFF_STATUS, 16'h0030);
    rdc(OFF_STATUS, st & 16'hFFCF, "status cleared");
    $display("test %s done", n);
  endtask : run

  initial begin
    logic [15:0] pst [3];
    pst = '{16'h0080, 16'h0082, 16'h0083};
    repeat (16) @(posedge i_clk_sys);
    i_rst <= 1'b0;
    rdc(OFF_STATUS, 16'h0080, "status reset");
    rdc(OFF_MODE, 16'(MODE_RST), "mode reset");
    rdc(OFF_PROT, 16'(PROT_RST), "prot reset");
    rdc(8'h10, 16'h0000, "unmapped");
    // Good program, then correctable and hard verify errors
    slot = '{16'h06FC, 16'h1000, 16'h1111, 16'h2222, 16'h3333, 16'h4444};
    rv = {slot[2], slot[3], slot[4], slot[5]};
    for (int i = 0; i < 3; i++) begin
      slot[1] = 16'h1000 + 16'(i * 8);
      run("program", 3'h5, 2, i == 1, i == 2, pst[i]);
      chk("prog addr", w_addr, {8'hFC, slot[1]});
      chk("prog data", w_data, rv);
    end
    rdc(OFF_INDEX, 16'h0005, "index");
    rdc(OFF_DATA, slot[5], "slot five");
    // Index, alignment, range, mode, code: refused with no array access
    for (int i = 0; i < 7; i++) begin
      slot[0] = i == 4 ? 16'h05FC : i == 2 ? 16'h06FB : i >= 5 ? 16'h0700 :
        16'h06FC;
      slot[1] = i == 1 ? 16'h2004 : i >= 5 ? 16'h0001 : 16'h2000;
      wr(OFF_MODE, i == 3 ? 16'h0002 : i == 5 ? 16'h0001 : 16'h0003);
      run("launch error", i % 6 == 0 ? 3'h3 : 3'h5,
        0, 0, 0, 16'h00A0);
    end
    wr(OFF_MODE, 16'h0003);
    // Protection boundary: first address inside, then just outside
    slot = '{16'h06FC, 16'h3000, 16'h1111, 16'h2222, 16'h3333, 16'h4444};
    wr(OFF_PROT, 16'h010C);
    run("protect", 3'h5, 0, 0, 0, 16'h0090);
    wr(OFF_PROT, 16'h010D);
    run("unprotect", 3'h5, 2, 0, 0, 16'h0080);
    wr(OFF_PROT, 16'h0000);
    // Write-once: blank phrase, programmed phrase, bad index, all-ones redo
    slot = '{16'h0700, 16'h0003, 16'h1234, 16'h5678, 16'h9ABC, 16'hDEF0};
    rv = {slot[2], slot[3], slot[4], slot[5]};
    blank_val = ERASED;
    run("once", 3'h5, 3, 0, 0, 16'h0080);
    chk("once addr", w_addr, ONCE_BASE + 24'h00_0018);
    chk("once info", w_info, 1'b1);
    blank_val = rv;
    run("once again", 3'h5, 1, 0, 0, 16'h00A0);
    slot[1] = 16'h0008;
    run("once range", 3'h5, 0, 0, 0, 16'h00A0);
    slot = '{16'h0700, 16'h0004, 16'hFFFF, 16'hFFFF, 16'hFFFF, 16'hFFFF};
    rv = ERASED;
    blank_val = ERASED;
    run("once ones", 3'h5, 3, 0, 0, 16'h0080);
    run("once ones redo", 3'h5, 3, 0, 0, 16'h0080);
    end_sim();
  end
endmodule : tb
